//--- cmd_check_checker.sv
// Concurrent checks on the APB ports of the command entry checker
`default_nettype none
module cmd_check_checker
   import cmd_check_pkg::*;
#(
   parameter int NSN = NS_MAX
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       done_c;
   logic       start_c;
   logic       mwr;
   logic       clr;
   logic       unmapped;
   logic [3:0] busy_cnt;
   assign done_c = psel && penable && pready;
   assign start_c = done_c && pwrite && paddr == ADDR_CTRL && pwdata[0]
                    && !pslverr && busy_cnt == 4'h0;
   assign mwr = done_c && pwrite && paddr == ADDR_INT_MASK;
   assign clr = mwr || (done_c && !pwrite && paddr == ADDR_INT_STATUS);
   assign unmapped = (paddr >= 12'h028 && paddr < 12'h040)
                     || paddr >= 12'h080;
   // Lower bound of busy only: APB traffic can stretch the walk further
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_cnt <= 4'h0;
      end else if (start_c) begin
         busy_cnt <= 4'h9;
      end else if (busy_cnt != 4'h0) begin
         busy_cnt <= busy_cnt - 4'h1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_access: assert property (pready |-> psel && penable
                                    && $past(psel && penable))
      else $error("pready outside an access phase");
   a_err_unmapped: assert property (done_c && unmapped |-> pslverr)
      else $error("unmapped address not refused");
   a_read_mapped: assert property (done_c && !pwrite && !unmapped
                                   |-> !pslverr)
      else $error("mapped read refused");
   a_start_busy: assert property (done_c && pwrite && paddr == ADDR_CTRL
                                  && busy_cnt != 4'h0 |-> pslverr)
      else $error("control write accepted while busy");
   a_window_busy: assert property (done_c && pwrite && busy_cnt != 4'h0
      && (paddr & ADDR_WINDOW_MASK) == ADDR_WINDOW |-> pslverr)
      else $error("entry write accepted while busy");
   a_irq_fall: assert property ($fell(irq) |-> $past(clr) || $past(clr, 2))
      else $error("irq dropped without clear or mask");
   a_irq_rise: assert property ($rose(irq) |-> $past(busy_cnt) <= 4'h1
                                || $past(mwr) || $past(mwr, 2))
      else $error("irq rose before the check finished");
   a_irq_masked: assert property (mwr && pwdata[2:0] == 3'h0 |-> ##2 !irq)
      else $error("irq high with all events masked");
   a_rdata_hold: assert property ($changed(prdata) |-> pready)
      else $error("read data changed without pready");
endmodule : cmd_check_checker
bind cmd_check_top cmd_check_checker #(.NSN(NSN)) cmd_check_checker_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

//--- cmd_check_pkg.sv
// Constants and types shared by the command entry checker
`default_nettype none
package cmd_check_pkg;
   // APB register byte addresses
   localparam logic [11:0] ADDR_CTRL        = 12'h000;
   localparam logic [11:0] ADDR_NS_COUNT    = 12'h004;
   localparam logic [11:0] ADDR_ACTIVE_MASK = 12'h008;
   localparam logic [11:0] ADDR_INT_STATUS  = 12'h00C;
   localparam logic [11:0] ADDR_INT_MASK    = 12'h010;
   localparam logic [11:0] ADDR_RESULT      = 12'h014;
   localparam logic [11:0] ADDR_COMMAND_DWORD_ZERO   = 12'h018;
   localparam logic [11:0] ADDR_NAMESPACE_IDENTIFIER = 12'h01C;
   localparam logic [11:0] ADDR_METADATA_POINTER_LO  = 12'h020;
   localparam logic [11:0] ADDR_METADATA_POINTER_HI  = 12'h024;
   localparam logic [11:0] ADDR_WINDOW      = 12'h040;
   localparam logic [11:0] ADDR_WINDOW_MASK = 12'hFC0;

   // Entry geometry and word positions
   localparam int          ENTRY_WORDS      = 16;
   localparam int          ENTRY_AW         = 4;
   localparam logic [3:0]  WORD_COMMAND_DWORD_ZERO   = 4'h0;
   localparam logic [3:0]  WORD_NAMESPACE_IDENTIFIER = 4'h1;
   localparam logic [3:0]  WORD_METADATA_POINTER_LO  = 4'h4;
   localparam logic [3:0]  WORD_METADATA_POINTER_HI  = 4'h5;

   // Fields of command dword zero
   localparam int          DESC_SEL_LSB     = 14;
   localparam logic [1:0]  DESC_SEL_CONTIG  = 2'h0;
   localparam logic [1:0]  DESC_SEL_BYTE    = 2'h1;
   localparam logic [1:0]  DESC_SEL_SEGMENT = 2'h2;

   // Namespace identifier special values
   localparam logic [31:0] NS_ID_UNUSED     = 32'h0000_0000;
   localparam logic [31:0] NS_ID_BROADCAST  = 32'hFFFF_FFFF;
   localparam int          NS_MAX           = 32;

   // Completion status codes
   localparam logic [7:0]  SC_SUCCESS       = 8'h00;
   localparam logic [7:0]  SC_INVALID_FIELD = 8'h02;
   localparam logic [7:0]  SC_INVALID_NS    = 8'h0B;

   // Control bits
   localparam int          CTRL_START       = 0;
   localparam int          CTRL_USES_NS     = 1;
   localparam int          CTRL_META_SEP    = 2;
   localparam int          CTRL_BCAST_OK    = 3;

   // Interrupt status bits
   localparam int          INT_W            = 3;
   localparam int          INT_DONE         = 0;
   localparam int          INT_ABORT        = 1;
   localparam int          INT_MISALIGN     = 2;

   // Reset values
   localparam logic [31:0] RST_NS_COUNT     = 32'h0000_0001;
   localparam logic [31:0] RST_ACTIVE_MASK  = 32'h0000_0001;

   typedef enum logic [2:0] {
      NS_NONE      = 3'h0,
      NS_BROADCAST = 3'h1,
      NS_ACTIVE    = 3'h2,
      NS_INACTIVE  = 3'h3,
      NS_INVALID   = 3'h4
   } ns_class_t;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0001,
      ST_FETCH   = 4'b0010,
      ST_CAPTURE = 4'b0100,
      ST_DECIDE  = 4'b1000
   } fsm_state_t;
endpackage : cmd_check_pkg
`default_nettype wire

//--- cmd_check_top.sv
// APB command entry checker: header decode, namespace and metadata checks
//
// Overview of operation
// - Command dword zero sits in bytes 03:00 and is decoded from there.
// - All-ones namespace identifier selects every accessible namespace.
// - Existing but inactive namespace aborts with Invalid Field in Command.
// - Invalid namespace identifier aborts with Invalid Namespace or Format.
// - Bytes 15:08 are reserved; their contents carry no meaning.
// - Metadata pointer used only when metadata is stored separately.
// - Descriptor select 00b: pointer is one contiguous metadata buffer.
// - Descriptor select 01b: contiguous buffer at any byte address.
// - Descriptor select 10b: quadword-aligned one-descriptor segment.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`default_nettype none
module cmd_check_top #(
   parameter int NSN = cmd_check_pkg::NS_MAX
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   output var  logic        irq
);
   import cmd_check_pkg::*;

   typedef struct packed {
      fsm_state_t      state;
      logic [1:0]      fidx;
      logic            pready;
      logic [31:0]     prdata;
      logic            pslverr;
      logic            irq;
      logic            uses_ns;
      logic            meta_sep;
      logic            bcast_ok;
      logic [31:0]     ns_count;
      logic [31:0]     active_mask;
      logic [INT_W-1:0] int_status;
      logic [INT_W-1:0] int_mask;
      logic [31:0]     command_dword_zero;
      logic [31:0]     namespace_identifier;
      logic [31:0]     metadata_pointer_lo;
      logic [31:0]     metadata_pointer_hi;
      logic [7:0]      status_code;
      ns_class_t       ns_class;
      logic            metadata_pointer_valid;
      logic            all_ns;
      logic            misaligned;
   } top_state_t;

   top_state_t  state_reg;
   top_state_t  state_next;

   logic            ram_we;
   logic            ram_rd_en;
   logic [3:0]      ram_raddr;
   logic [31:0]     ram_rdata;
   ns_class_t       cls;
   logic            apb_setup;
   logic            apb_access;
   logic            busy;
   logic [1:0]      transfer_descriptor_type_select;
   logic [INT_W-1:0] events;

   function automatic logic in_window(input logic [11:0] a);
      in_window = (a & ADDR_WINDOW_MASK) == ADDR_WINDOW;
   endfunction : in_window

   // Reserved words 2 and 3 are never fetched
   function automatic logic [3:0] fetch_word(input logic [1:0] k);
      unique case (k)
         2'h0:    fetch_word = WORD_COMMAND_DWORD_ZERO;
         2'h1:    fetch_word = WORD_NAMESPACE_IDENTIFIER;
         2'h2:    fetch_word = WORD_METADATA_POINTER_LO;
         default: fetch_word = WORD_METADATA_POINTER_HI;
      endcase
   endfunction : fetch_word

   assign apb_setup  = psel & ~penable;
   assign apb_access = psel & penable;
   assign busy       = state_reg.state != ST_IDLE;
   assign transfer_descriptor_type_select =
      state_reg.command_dword_zero[DESC_SEL_LSB+1:DESC_SEL_LSB];

   // Entry writes land at the completing edge unless refused; the walk may
   // end between decode and completion, so the latched refusal decides
   assign ram_we = apb_access & state_reg.pready & pwrite
                   & ~state_reg.pslverr & in_window(paddr);

   // Bus reads own the single read port; the walk's fetch steps wait while psel is high
   always_comb begin
      ram_rd_en = 1'b0;
      ram_raddr = fetch_word(state_reg.fidx);
      if (apb_setup & ~pwrite & in_window(paddr)) begin
         ram_rd_en = 1'b1;
         ram_raddr = paddr[5:2];
      end else if (state_reg.state == ST_FETCH && !psel) begin
         ram_rd_en = 1'b1;
      end
   end

   entry_word_ram #(
      .WORDS (ENTRY_WORDS),
      .AW    (ENTRY_AW)
   ) u_ram (
      .pclk  (pclk),
      .we    (ram_we),
      .waddr (paddr[5:2]),
      .wdata (pwdata),
      .rd_en (ram_rd_en),
      .raddr (ram_raddr),
      .rdata (ram_rdata)
   );

   namespace_identifier_classifier #(
      .NSN                  (NSN)
   ) u_cls (
      .namespace_identifier (state_reg.namespace_identifier),
      .ns_count             (state_reg.ns_count),
      .active_mask          (state_reg.active_mask[NSN-1:0]),
      .ns_class             (cls)
   );

   always_comb begin
      state_next = state_reg;
      events     = '0;

      unique case (state_reg.state)
         ST_IDLE: begin
         end
         ST_FETCH: begin
            if (!psel) begin
               state_next.state = ST_CAPTURE;
            end
         end
         ST_CAPTURE: begin
            unique case (state_reg.fidx)
               2'h0:    state_next.command_dword_zero   = ram_rdata;
               2'h1:    state_next.namespace_identifier = ram_rdata;
               2'h2:    state_next.metadata_pointer_lo  = ram_rdata;
               default: state_next.metadata_pointer_hi  = ram_rdata;
            endcase
            if (state_reg.fidx == 2'h3) begin
               state_next.state = ST_DECIDE;
            end else begin
               state_next.fidx  = state_reg.fidx + 2'h1;
               state_next.state = ST_FETCH;
            end
         end
         ST_DECIDE: begin
            state_next.state       = ST_IDLE;
            state_next.ns_class    = cls;
            state_next.status_code = SC_SUCCESS;
            state_next.all_ns      = 1'b0;
            state_next.misaligned  = 1'b0;
            // Identifier is ignored when unused; host is trusted to zero it
            if (state_reg.uses_ns) begin
               unique case (cls)
                  NS_BROADCAST: begin
                     if (state_reg.bcast_ok) begin
                        state_next.all_ns = 1'b1;
                     end else begin
                        state_next.status_code = SC_INVALID_NS;
                     end
                  end
                  NS_ACTIVE: begin
                  end
                  NS_INACTIVE: begin
                     state_next.status_code = SC_INVALID_FIELD;
                  end
                  default: begin
                     state_next.status_code = SC_INVALID_NS;
                  end
               endcase
            end
            state_next.metadata_pointer_valid = state_reg.meta_sep;
            if (state_reg.meta_sep) begin
               unique case (transfer_descriptor_type_select)
                  DESC_SEL_CONTIG: begin
                     // Contiguous buffer; misalignment only flagged
                     state_next.misaligned =
                        state_reg.metadata_pointer_lo[1:0] != 2'h0;
                  end
                  DESC_SEL_BYTE: begin
                     state_next.misaligned = 1'b0;
                  end
                  DESC_SEL_SEGMENT: begin
                     state_next.misaligned =
                        state_reg.metadata_pointer_lo[2:0] != 3'h0;
                  end
                  default: begin
                     if (state_next.status_code == SC_SUCCESS) begin
                        state_next.status_code = SC_INVALID_FIELD;
                     end
                  end
               endcase
            end
            events[INT_DONE]     = 1'b1;
            events[INT_ABORT]    = state_next.status_code != SC_SUCCESS;
            events[INT_MISALIGN] = state_next.misaligned;
         end
      endcase

      // APB: first access cycle decodes, second completes the transfer
      if (apb_access && !state_reg.pready) begin
         state_next.pready  = 1'b1;
         state_next.pslverr = 1'b0;
         state_next.prdata  = 32'h0000_0000;
         if (in_window(paddr)) begin
            if (pwrite) begin
               state_next.pslverr = busy;
            end else begin
               state_next.prdata = ram_rdata;
            end
         end else begin
            unique case (paddr)
               ADDR_CTRL: begin
                  state_next.prdata = {28'h0000000, state_reg.bcast_ok,
                     state_reg.meta_sep, state_reg.uses_ns, 1'b0};
                  state_next.pslverr = pwrite & busy;
               end
               ADDR_NS_COUNT:    state_next.prdata = state_reg.ns_count;
               ADDR_ACTIVE_MASK: state_next.prdata = state_reg.active_mask;
               ADDR_INT_STATUS: begin
                  state_next.prdata = {29'h00000000, state_reg.int_status};
               end
               ADDR_INT_MASK: begin
                  state_next.prdata = {29'h00000000, state_reg.int_mask};
               end
               ADDR_RESULT: begin
                  state_next.prdata = {15'h0000, state_reg.misaligned,
                     transfer_descriptor_type_select, state_reg.all_ns,
                     state_reg.metadata_pointer_valid, busy,
                     state_reg.ns_class, state_reg.status_code};
               end
               ADDR_COMMAND_DWORD_ZERO: begin
                  state_next.prdata = state_reg.command_dword_zero;
               end
               ADDR_NAMESPACE_IDENTIFIER: begin
                  state_next.prdata = state_reg.namespace_identifier;
               end
               ADDR_METADATA_POINTER_LO: begin
                  state_next.prdata = state_reg.metadata_pointer_lo;
               end
               ADDR_METADATA_POINTER_HI: begin
                  state_next.prdata = state_reg.metadata_pointer_hi;
               end
               default:          state_next.pslverr = 1'b1;
            endcase
         end
      end else if (apb_access && state_reg.pready) begin
         state_next.pready  = 1'b0;
         state_next.pslverr = 1'b0;
         if (!state_reg.pslverr) begin
            if (pwrite) begin
               unique case (paddr)
                  ADDR_CTRL: begin
                     state_next.uses_ns  = pwdata[CTRL_USES_NS];
                     state_next.meta_sep = pwdata[CTRL_META_SEP];
                     state_next.bcast_ok = pwdata[CTRL_BCAST_OK];
                     if (pwdata[CTRL_START]) begin
                        state_next.state = ST_FETCH;
                        state_next.fidx  = 2'h0;
                     end
                  end
                  ADDR_NS_COUNT:    state_next.ns_count    = pwdata;
                  ADDR_ACTIVE_MASK: state_next.active_mask = pwdata;
                  ADDR_INT_MASK: begin
                     state_next.int_mask = pwdata[INT_W-1:0];
                  end
                  default: begin
                  end
               endcase
            end else if (paddr == ADDR_INT_STATUS) begin
               // Read clears; events of this same cycle are merged below
               state_next.int_status = '0;
            end
         end
      end else begin
         state_next.pready  = 1'b0;
         state_next.pslverr = 1'b0;
      end

      // Set wins over the read clear
      state_next.int_status = state_next.int_status | events;
      state_next.irq = |(state_next.int_status & state_next.int_mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg             <= '0;
         state_reg.state       <= ST_IDLE;
         state_reg.ns_class    <= NS_NONE;
         state_reg.status_code <= SC_SUCCESS;
         state_reg.ns_count    <= RST_NS_COUNT;
         state_reg.active_mask <= RST_ACTIVE_MASK;
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata  = state_reg.prdata;
   assign pready  = state_reg.pready;
   assign pslverr = state_reg.pslverr;
   assign irq     = state_reg.irq;
endmodule : cmd_check_top
`default_nettype wire

//--- entry_word_ram.sv
// Small word memory holding one command entry, registered read port
`default_nettype none
module entry_word_ram #(
   parameter int WORDS = cmd_check_pkg::ENTRY_WORDS,
   parameter int AW    = cmd_check_pkg::ENTRY_AW
) (
   input  wire logic          pclk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [31:0]   wdata,
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] raddr,
   output var  logic [31:0]   rdata
);
   import cmd_check_pkg::*;

   logic [31:0] mem [WORDS];

   // No reset on the array: contents are undefined until software fills it
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (rd_en) begin
         rdata <= mem[raddr];
      end
   end
endmodule : entry_word_ram
`default_nettype wire

//--- host_entry_model.sv
// Host side model that builds the header words of one command entry
`default_nettype none
module host_entry_model (
   input  wire logic             uses_ns,
   input  wire logic             skew,
   input  wire logic             junk,
   input  wire logic [1:0]       sel,
   input  wire logic [31:0]      ns_id,
   input  wire logic [31:0]      meta_lo,
   output var  logic [5:0][31:0] entry
);
   timeunit 1ns;
   timeprecision 1ps;
   always_comb begin
      entry[0] = {16'h0000, sel, 14'h0001};
      entry[1] = uses_ns ? ns_id : 32'h0000_0000;
      entry[2] = junk ? 32'hA5A5_5A5A : 32'h0000_0000;
      entry[3] = junk ? 32'h5A5A_A5A5 : 32'h0000_0000;
      // A careful host aligns; skew breaks that when a test asks for it
      entry[4] = meta_lo;
      if (!skew && sel == 2'h0) entry[4][1:0] = 2'h0;
      if (!skew && sel == 2'h2) entry[4][2:0] = 3'h0;
      entry[5] = 32'h0000_0000;
   end
endmodule : host_entry_model
`default_nettype wire

//--- namespace_identifier_classifier.sv
// Sorts a namespace identifier into unused, broadcast, active, etc.
`default_nettype none
module namespace_identifier_classifier #(
   parameter int NSN = cmd_check_pkg::NS_MAX
) (
   input  wire logic [31:0]             namespace_identifier,
   input  wire logic [31:0]             ns_count,
   input  wire logic [NSN-1:0]          active_mask,
   output var  cmd_check_pkg::ns_class_t ns_class
);
   import cmd_check_pkg::*;

   logic [31:0] idx;

   always_comb begin
      idx      = namespace_identifier - 32'h0000_0001;
      ns_class = NS_INVALID;
      if (namespace_identifier == NS_ID_UNUSED) begin
         ns_class = NS_NONE;
      end else if (namespace_identifier == NS_ID_BROADCAST) begin
         ns_class = NS_BROADCAST;
      end else if (namespace_identifier <= ns_count && idx < NSN) begin
         // Existing namespace: active only if its mask bit is set
         ns_class = active_mask[idx[$clog2(NSN)-1:0]] ? NS_ACTIVE
                                                      : NS_INACTIVE;
      end
   end
endmodule : namespace_identifier_classifier
`default_nettype wire

//--- tb_cmd_check_top.sv
// Self-checking APB testbench for the command entry checker
`default_nettype none
module tb_cmd_check_top;
   import cmd_check_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic             pclk = 1'b0;
   logic             presetn = 1'b0;
   logic             psel = 1'b0;
   logic             penable = 1'b0;
   logic             pwrite = 1'b0;
   logic [11:0]      paddr = 12'h000;
   logic [31:0]      pwdata = 32'h0000_0000;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic             irq;
   logic             h_u = 1'b0;
   logic             h_sk = 1'b0;
   logic             h_j = 1'b0;
   logic [1:0]       h_p = 2'h0;
   logic [31:0]      h_ns = 32'h0000_0000;
   logic [31:0]      h_ml = 32'h0000_0000;
   logic [5:0][31:0] ent;
   logic [31:0]      r;
   logic             e;
   int               n_mismatch = 0;
   int               n_compared = 0;
   always #10 pclk = ~pclk;
   cmd_check_top cmd_check_top_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq));
   host_entry_model host_entry_model_inst (.uses_ns(h_u), .skew(h_sk),
      .junk(h_j), .sel(h_p), .ns_id(h_ns), .meta_lo(h_ml), .entry(ent));
   task results;
      $display("TB: compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(r, exp);
   endtask : rd_chk
   task run_case(input logic [2:0] mk, input logic u, m, b, sk, j,
                 input logic [1:0] p, input logic [31:0] ns, ml,
                 input logic [7:0] st, input logic [2:0] cl,
                 input logic al, mi);
      logic [2:0] ev;
      int         k;
      ev = {mi, st != 8'h00, 1'b1};
      {h_u, h_sk, h_j, h_p, h_ns, h_ml} = {u, sk, j, p, ns, ml};
      apb(1'b1, ADDR_INT_MASK, {29'h0, mk});
      for (k = 0; k < 6; k++) apb(1'b1, ADDR_WINDOW + 12'(4 * k), ent[k]);
      apb(1'b1, ADDR_CTRL, {28'h0, b, m, u, 1'b1});
      k = 0;
      do begin
         apb(1'b0, ADDR_RESULT, 32'h0000_0000);
         k++;
      end while (r[11] !== 1'b0 && k < 40);
      // Pointer validity and misalignment with the unused select value are left open
      chk(r & (p == 2'h3 ? 32'h0EFFF : 32'h1FFFF),
          {15'h0, mi, p, al, m && p != 2'h3, 1'b0, cl, st});
      rd_chk(ADDR_RESULT + 12'h004, ent[0]);
      rd_chk(ADDR_RESULT + 12'h008, ent[1]);
      rd_chk(ADDR_RESULT + 12'h00C, ent[4]);
      rd_chk(ADDR_RESULT + 12'h010, ent[5]);
      rd_chk(ADDR_CTRL, {28'h0, b, m, u, 1'b0});
      chk({31'h0, irq}, {31'h0, |(mk & ev)});
      rd_chk(ADDR_INT_STATUS, {29'h0, ev});
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0000_0000);
      $display("TB: case done namespace=%h select=%h", ns, p);
   endtask : run_case
   initial begin
      #200000;
      n_mismatch++;
      results();
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(ADDR_CTRL, 32'h0000_0000);
      rd_chk(ADDR_NS_COUNT, RST_NS_COUNT);
      rd_chk(ADDR_ACTIVE_MASK, RST_ACTIVE_MASK);
      rd_chk(ADDR_INT_STATUS, 32'h0000_0000);
      rd_chk(ADDR_INT_MASK, 32'h0000_0000);
      rd_chk(ADDR_RESULT, 32'h0000_0000);
      apb(1'b0, 12'h030, 32'h0000_0000);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, 12'h0A0, 32'h0000_0000);
      chk({31'h0, e}, 32'h1);
      $display("TB: reset and map test done");
      apb(1'b1, ADDR_NS_COUNT, 32'h0000_0004);
      apb(1'b1, ADDR_ACTIVE_MASK, 32'h0000_0005);
      run_case(7, 1, 1, 0, 0, 0, 0, 1, 32'h1000, 0, 2, 0, 0);
      run_case(7, 1, 0, 0, 0, 0, 0, 2, 0, 8'h02, 3, 0, 0);
      run_case(7, 1, 0, 0, 0, 0, 0, 5, 0, 8'h0B, 4, 0, 0);
      run_case(7, 1, 0, 0, 0, 0, 0, 0, 0, 8'h0B, 0, 0, 0);
      run_case(7, 1, 0, 1, 0, 0, 0, '1, 0, 0, 1, 1, 0);
      run_case(7, 1, 0, 0, 0, 0, 0, '1, 0, 8'h0B, 1, 0, 0);
      run_case(7, 0, 0, 0, 0, 0, 0, 3, 0, 0, 0, 0, 0);
      run_case(7, 1, 1, 0, 1, 0, 0, 1, 32'h1002, 0, 2, 0, 1);
      run_case(7, 1, 1, 0, 1, 0, 1, 1, 32'h1003, 0, 2, 0, 0);
      run_case(7, 1, 1, 0, 1, 0, 2, 1, 32'h1004, 0, 2, 0, 1);
      run_case(7, 1, 1, 0, 0, 0, 2, 1, 32'h100C, 0, 2, 0, 0);
      run_case(7, 1, 0, 0, 1, 0, 2, 1, 32'h1003, 0, 2, 0, 0);
      run_case(0, 1, 1, 0, 0, 0, 3, 1, 0, 8'h02, 2, 0, 0);
      run_case(4, 1, 1, 0, 0, 1, 0, 1, 32'h1000, 0, 2, 0, 0);
      apb(1'b1, ADDR_CTRL, 32'h0000_0001);
      apb(1'b1, ADDR_CTRL, 32'h0000_0001);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, ADDR_WINDOW, 32'h0000_0000);
      chk({31'h0, e}, 32'h1);
      repeat (20) @(posedge pclk);
      rd_chk(ADDR_INT_STATUS, 32'h0000_0001);
      rd_chk(ADDR_WINDOW, ent[0]);
      $display("TB: busy refusal test done");
      results();
   end
endmodule : tb_cmd_check_top
`default_nettype wire
